/* rtl/uetc_ep0_tx.sv */
// control endpoint transmit fifo, length, control and link answer logic
//
// Overview of operation
// - each register write to the data port appends one byte to the fifo unless the fifo is full or a clear or function reset comes in the same cycle
// - a write to the length register sets the arm bit unless a setup stage, clear or function reset comes in the same cycle
// - the length register holds its value while bytes are sent
// - clear bit resets fifo pointers and flags, then clears itself
// - after clear the empty flag is set and other flags cleared
// - stall bit makes the next valid in transaction answer stall
// - successful setup stage clears the stall bit
// - armed fifo contents go out on the next valid in transaction
// - arm bit clears when the transmit acknowledge status sets, unless a length write comes in the same cycle
// - setup stage or fifo clear also clears the arm bit
// - unarmed valid in transaction is answered with nack
// - stall bit replaces that nack with a stall handshake
// - control bit 0 enables the transmit direction
// - either enable clear keeps the function port disconnected
// - acknowledged data packet sets ack status and transmit interrupt
// - function reset leaves both enables untouched
`timescale 1ns/1ps
module uetc_ep0_tx (
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire uetc_pkg::uetc_reg_req_type  reg_req,
    output logic [7:0]                       reg_rdata,
    input  wire logic                        endpoint_rx_enable,
    input  wire uetc_pkg::uetc_link_evt_type link_evt,
    output uetc_pkg::uetc_answer_type        answer,
    output logic                             answer_valid,
    output logic [7:0]                       tx_byte,
    output logic                             tx_last,
    output logic                             ack_status,
    output logic                             tx_irq,
    output logic                             port_disconnect
);
    logic [7:0]                    fifo_mem [uetc_pkg::FIFO_DEPTH];
    logic [uetc_pkg::PTR_W:0]      wr_ptr_reg;
    logic [uetc_pkg::PTR_W:0]      rd_ptr_reg;
    logic [3:0]                    length_reg;
    logic [3:0]                    sent_reg;
    logic                          clear_reg;
    logic                          stall_reg;
    logic                          arm_reg;
    logic                          tx_en_reg;
    logic                          ack_reg;
    logic                          overrun_reg;
    logic                          underrun_reg;
    logic                          sending_reg;
    logic [uetc_pkg::PTR_W:0]      level;
    logic                          fifo_empty;
    logic                          fifo_full;
    logic                          wr_data;
    logic                          wr_len;
    logic                          wr_ctl;
    logic                          take;
    logic                          function_reset_irq;

    // pointer difference, used for both flags and the level
    function automatic logic [uetc_pkg::PTR_W:0] ptr_diff(
        input logic [uetc_pkg::PTR_W:0] a,
        input logic [uetc_pkg::PTR_W:0] b
    );
        ptr_diff = a - b;
    endfunction : ptr_diff

    assign level      = ptr_diff(wr_ptr_reg, rd_ptr_reg);
    assign fifo_empty = (level == '0);
    assign fifo_full  = (level == (uetc_pkg::PTR_W + 1)'(uetc_pkg::FIFO_DEPTH));
    assign wr_data    = reg_req.wr && (reg_req.addr == uetc_pkg::ADDR_FIFO_DATA);
    assign wr_len     = reg_req.wr && (reg_req.addr == uetc_pkg::ADDR_PKT_LENGTH);
    assign wr_ctl     = reg_req.wr && (reg_req.addr == uetc_pkg::ADDR_TX_CONTROL);
    assign take       = sending_reg && link_evt.byte_take;
    assign function_reset_irq       = link_evt.func_reset;

    // fifo write side; a write into a full fifo is dropped and flags over-run
    // append written byte
    always_ff @(posedge ref_clk) begin
        if (wr_data && !fifo_full) begin
            fifo_mem[wr_ptr_reg[uetc_pkg::PTR_W-1:0]] <= reg_req.wdata;
        end
    end

    // pointers; clear and function reset win over any traffic
    // clear resets pointers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (clear_reg || function_reset_irq) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (wr_data && !fifo_full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (take && !fifo_empty) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // error flags; the fifo clear wins so a reset always ends with only empty set
    // clear leaves only empty set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overrun_reg  <= 1'b0;
            underrun_reg <= 1'b0;
        end else if (clear_reg || function_reset_irq) begin
            overrun_reg  <= 1'b0;
            underrun_reg <= 1'b0;
        end else begin
            if (wr_data && fifo_full) begin
                overrun_reg <= 1'b1;
            end
            if (take && fifo_empty) begin
                underrun_reg <= 1'b1;
            end
        end
    end

    // packet length register, only software writes and function reset change it
    // no count down while sending
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            length_reg <= uetc_pkg::LEN_RESET;
        end else if (function_reset_irq) begin
            length_reg <= uetc_pkg::LEN_RESET;
        end else if (wr_len) begin
            length_reg <= reg_req.wdata[3:0];
        end
    end

    // clear bit holds for one cycle then the device drops it
    // self clearing clear bit
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clear_reg <= 1'b0;
        end else begin
            clear_reg <= wr_ctl && reg_req.wdata[uetc_pkg::CTL_CLEAR_POS] && !function_reset_irq;
        end
    end

    // stall bit; software write loses to a simultaneous setup stage
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stall_reg <= 1'b0;
        end else if (link_evt.setup_ok || function_reset_irq) begin
            stall_reg <= 1'b0;
        end else if (wr_ctl) begin
            stall_reg <= reg_req.wdata[uetc_pkg::CTL_STALL_POS];
        end
    end

    // arm bit; set by length write, cleared on ack, setup or fifo clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            arm_reg <= 1'b0;
        end else if (link_evt.setup_ok || clear_reg || function_reset_irq) begin
            arm_reg <= 1'b0;
        end else if (wr_len) begin
            arm_reg <= 1'b1;
        end else if (sending_reg && link_evt.host_ack) begin
            arm_reg <= 1'b0;
        end else if (wr_ctl) begin
            arm_reg <= reg_req.wdata[uetc_pkg::CTL_ARM_POS];
        end
    end

    // transmit enable survives a function reset
    // enable kept over function reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_en_reg <= 1'b0;
        end else if (wr_ctl) begin
            tx_en_reg <= reg_req.wdata[uetc_pkg::CTL_TX_EN_POS];
        end
    end

    // sending state; data phase lasts from the in token until the host ack
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sending_reg <= 1'b0;
            sent_reg    <= '0;
        end else if (link_evt.setup_ok || clear_reg || function_reset_irq) begin
            sending_reg <= 1'b0;
            sent_reg    <= '0;
        end else if (link_evt.in_valid && tx_en_reg && !stall_reg && arm_reg && !sending_reg) begin
            sending_reg <= 1'b1;
            sent_reg    <= '0;
        end else if (sending_reg && link_evt.host_ack) begin
            sending_reg <= 1'b0;
        end else if (take) begin
            sent_reg <= sent_reg + 1'b1;
        end
    end

    // ack status; hardware set wins over the clear by setup stage or function reset
    // ack sets status
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else if (sending_reg && link_evt.host_ack) begin
            ack_reg <= 1'b1;
        end else if (link_evt.setup_ok || function_reset_irq) begin
            ack_reg <= 1'b0;
        end
    end

    // answer selection, combinational handshake output
    always_comb begin
        answer_valid = link_evt.in_valid && tx_en_reg;
        if (stall_reg) begin
            answer = uetc_pkg::UETC_ANS_STALL;
        end else if (arm_reg) begin
            answer = uetc_pkg::UETC_ANS_DATA;
        end else begin
            answer = uetc_pkg::UETC_ANS_NACK;
        end
    end

    // data byte and last marker from flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_byte <= 8'h00;
            tx_last <= 1'b0;
        end else begin
            tx_byte <= fifo_mem[rd_ptr_reg[uetc_pkg::PTR_W-1:0]];
            tx_last <= (sent_reg + 4'h1 >= length_reg) || (length_reg == 4'h0);
        end
    end

    // read back; reserved bits read zero
    always_comb begin
        reg_rdata = 8'h00;
        case (reg_req.addr)
            uetc_pkg::ADDR_PKT_LENGTH: reg_rdata = {4'h0, length_reg};
            uetc_pkg::ADDR_TX_CONTROL: begin
                reg_rdata[uetc_pkg::CTL_CLEAR_POS] = clear_reg;
                reg_rdata[uetc_pkg::CTL_STALL_POS] = stall_reg;
                reg_rdata[uetc_pkg::CTL_ARM_POS]   = arm_reg;
                reg_rdata[uetc_pkg::CTL_TX_EN_POS] = tx_en_reg;
            end
            uetc_pkg::ADDR_TX_FLAGS: begin
                reg_rdata[uetc_pkg::FLG_EMPTY_POS]    = fifo_empty;
                reg_rdata[uetc_pkg::FLG_FULL_POS]     = fifo_full;
                reg_rdata[uetc_pkg::FLG_UNDERRUN_POS] = underrun_reg;
                reg_rdata[uetc_pkg::FLG_OVERRUN_POS]  = overrun_reg;
            end
            default: reg_rdata = 8'h00;
        endcase
    end

    assign ack_status = ack_reg;
    assign tx_irq     = ack_reg || overrun_reg || underrun_reg;
    assign port_disconnect = !(tx_en_reg && endpoint_rx_enable);

    AST_LEN_ARMS: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_len && !link_evt.setup_ok && !clear_reg && !function_reset_irq |=> arm_reg)
        else $error("length write did not arm");
    AST_CLR_SELF: assert property (@(posedge ref_clk) disable iff (!resetn)
        clear_reg |=> !clear_reg)
        else $error("clear bit not self clearing");
    AST_CLR_EMPTY: assert property (@(posedge ref_clk) disable iff (!resetn)
        clear_reg |=> fifo_empty && !overrun_reg && !underrun_reg)
        else $error("flags wrong after clear");
    AST_SETUP_STALL: assert property (@(posedge ref_clk) disable iff (!resetn)
        link_evt.setup_ok |=> !stall_reg)
        else $error("stall survived setup");
    AST_ACK_DISARM: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(ack_reg) |-> !arm_reg || $past(wr_len))
        else $error("arm held after ack");
    AST_LEN_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
        !wr_len && !function_reset_irq |=> $stable(length_reg))
        else $error("length changed");
    AST_STALL_ANS: assert property (@(posedge ref_clk) disable iff (!resetn)
        stall_reg |-> answer == uetc_pkg::UETC_ANS_STALL)
        else $error("stall not answered");
    // disconnected while the transmit enable is low
    AST_DISCONNECT: assert property (@(posedge ref_clk) disable iff (!resetn)
        !tx_en_reg |-> port_disconnect)
        else $error("port connected while disabled");
endmodule : uetc_ep0_tx

/* rtl/uetc_pkg.sv */
// shared constants and carriers for the control endpoint transmit block
package uetc_pkg;
    // register indices on the local register port
    localparam logic [1:0] ADDR_FIFO_DATA  = 2'h0;
    localparam logic [1:0] ADDR_PKT_LENGTH = 2'h1;
    localparam logic [1:0] ADDR_TX_CONTROL = 2'h2;
    localparam logic [1:0] ADDR_TX_FLAGS   = 2'h3;
    // control register bit positions
    localparam int CTL_CLEAR_POS  = 7;
    localparam int CTL_STALL_POS  = 3;
    localparam int CTL_ARM_POS    = 1;
    localparam int CTL_TX_EN_POS  = 0;
    // flags register bit positions
    localparam int FLG_EMPTY_POS   = 3;
    localparam int FLG_FULL_POS    = 2;
    localparam int FLG_UNDERRUN_POS = 1;
    localparam int FLG_OVERRUN_POS = 0;
    // fifo geometry and reset values
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W      = 3;
    localparam logic [3:0] LEN_RESET  = 4'h0;
    localparam logic [7:0] CTL_RESET  = 8'h00;

    // answer the link logic asks for on a valid in transaction
    typedef enum logic [1:0] {UETC_ANS_NACK, UETC_ANS_STALL, UETC_ANS_DATA} uetc_answer_type;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } uetc_reg_req_type;

    // link-side events
    typedef struct packed {
        logic in_valid;   // valid in token for the control endpoint
        logic setup_ok;   // setup stage received successfully
        logic byte_take;  // link consumes the presented data byte
        logic host_ack;   // host acknowledged the data packet
        logic func_reset; // function reset from the hub port
    } uetc_link_evt_type;
endpackage : uetc_pkg

/* test/uetc_host_model.sv */
// host side model issuing setup, reset and in transactions toward the control endpoint
`timescale 1ns/1ps
module uetc_host_model (
    input  wire logic                      ref_clk,
    input  wire uetc_pkg::uetc_answer_type answer,
    input  wire logic                      answer_valid,
    input  wire logic [7:0]                tx_byte,
    input  wire logic                      tx_last,
    output uetc_pkg::uetc_link_evt_type    link_evt
);
    uetc_pkg::uetc_answer_type got_ans;
    logic                      got_valid;
    logic [7:0]                got_q[$];

    initial link_evt = '0;

    // one cycle pulse on one event field: 3 setup, 1 host ack, 0 function reset
    task automatic pulse(input int idx);
        @(posedge ref_clk);
        link_evt <= uetc_pkg::uetc_link_evt_type'(5'h01 << idx);
        @(posedge ref_clk);
        link_evt <= '0;
    endtask : pulse

    // one in transaction; answer sampled mid-cycle while the token is up
    task automatic in_txn(input logic ack_it);
        logic last;
        int   k;
        got_q.delete();
        last = 1'b0;
        @(posedge ref_clk);
        link_evt.in_valid <= 1'b1;
        @(negedge ref_clk);
        got_ans   = answer;
        got_valid = answer_valid;
        @(posedge ref_clk);
        link_evt.in_valid <= 1'b0;
        // pull packet bytes
        // slack after each take because the head byte is registered twice over
        for (k = 0; k < 16 && got_ans === uetc_pkg::UETC_ANS_DATA && last !== 1'b1; k++) begin
            @(negedge ref_clk);
            got_q.push_back(tx_byte);
            last = tx_last;
            @(posedge ref_clk);
            link_evt.byte_take <= 1'b1;
            @(posedge ref_clk);
            link_evt.byte_take <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        if (ack_it) begin
            pulse(1);
        end
    endtask : in_txn
endmodule : uetc_host_model

/* test/usb_ep0_tx_control_tb.sv */
// self-checking bench for the control endpoint transmit block
`timescale 1ns/1ps
module usb_ep0_tx_control_tb;
    logic                        ref_clk = 1'b0;
    logic                        resetn;
    uetc_pkg::uetc_reg_req_type  reg_req;
    logic [7:0]                  reg_rdata;
    logic                        endpoint_rx_enable;
    uetc_pkg::uetc_link_evt_type link_evt;
    uetc_pkg::uetc_answer_type   answer;
    logic                        answer_valid;
    logic [7:0]                  tx_byte;
    logic                        tx_last;
    logic                        ack_status;
    logic                        tx_irq;
    logic                        port_disconnect;
    int                          err_total = 0;
    int                          compares  = 0;
    int                          cycles    = 0;
    logic [7:0]                  v;

    always #12.5 ref_clk = ~ref_clk;

    uetc_ep0_tx uut (
        .ref_clk            (ref_clk),
        .resetn             (resetn),
        .reg_req            (reg_req),
        .reg_rdata          (reg_rdata),
        .endpoint_rx_enable (endpoint_rx_enable),
        .link_evt           (link_evt),
        .answer             (answer),
        .answer_valid       (answer_valid),
        .tx_byte            (tx_byte),
        .tx_last            (tx_last),
        .ack_status         (ack_status),
        .tx_irq             (tx_irq),
        .port_disconnect    (port_disconnect)
    );

    uetc_host_model host (
        .ref_clk      (ref_clk),
        .answer       (answer),
        .answer_valid (answer_valid),
        .tx_byte      (tx_byte),
        .tx_last      (tx_last),
        .link_evt     (link_evt)
    );

    task automatic wrap_up();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // register write, one idle cycle after so strobes never collide
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask : reg_wr

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk);
        v = reg_rdata;
        @(posedge ref_clk);
        reg_req <= '0;
        if (what != "") check(what, exp, v);
    endtask : rd_chk

    task automatic ans_chk(input uetc_pkg::uetc_answer_type exp);
        check("answer", {6'h00, exp}, {6'h00, host.got_ans});
        check("answer_valid", 8'h01, {7'h00, host.got_valid});
    endtask : ans_chk

    // hang guard, tests need well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        reg_req = '0;
        endpoint_rx_enable = 1'b0;
        resetn = 1'b0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_chk(uetc_pkg::ADDR_TX_CONTROL, uetc_pkg::CTL_RESET, "ctl reset");
        rd_chk(uetc_pkg::ADDR_PKT_LENGTH, {4'h0, uetc_pkg::LEN_RESET}, "len reset");
        check("disconnect", 8'h01, {7'h00, port_disconnect});
        reg_wr(uetc_pkg::ADDR_TX_CONTROL, 8'h01);
        // the enable lands at the edge the write task returns on, so look later
        @(negedge ref_clk);
        check("disconnect", 8'h01, {7'h00, port_disconnect});
        @(posedge ref_clk);
        endpoint_rx_enable <= 1'b1;
        @(negedge ref_clk);
        check("disconnect", 8'h00, {7'h00, port_disconnect});
        host.in_txn(1'b0);
        ans_chk(uetc_pkg::UETC_ANS_NACK);
        reg_wr(uetc_pkg::ADDR_TX_CONTROL, 8'h09);
        host.in_txn(1'b0);
        ans_chk(uetc_pkg::UETC_ANS_STALL);
        host.pulse(3);
        rd_chk(uetc_pkg::ADDR_TX_CONTROL, 8'h01, "stall after setup");
        // three byte packet, length written last to arm
        reg_wr(uetc_pkg::ADDR_FIFO_DATA, 8'ha1);
        reg_wr(uetc_pkg::ADDR_FIFO_DATA, 8'hb2);
        reg_wr(uetc_pkg::ADDR_FIFO_DATA, 8'hc3);
        reg_wr(uetc_pkg::ADDR_PKT_LENGTH, 8'h03);
        rd_chk(uetc_pkg::ADDR_TX_CONTROL, 8'h03, "armed");
        host.in_txn(1'b1);
        ans_chk(uetc_pkg::UETC_ANS_DATA);
        check("count", 8'h03, 8'(host.got_q.size()));
        for (int i = 0; i < 3 && i < host.got_q.size(); i++) begin
            check("byte", 8'ha1 + 8'(i) * 8'h11, host.got_q[i]);
        end
        rd_chk(uetc_pkg::ADDR_PKT_LENGTH, 8'h03, "len held");
        check("ack_status", 8'h01, {7'h00, ack_status});
        check("tx_irq", 8'h01, {7'h00, tx_irq});
        rd_chk(uetc_pkg::ADDR_TX_CONTROL, 8'h01, "arm after ack");
        host.in_txn(1'b0);
        ans_chk(uetc_pkg::UETC_ANS_NACK);
        reg_wr(uetc_pkg::ADDR_PKT_LENGTH, 8'h01);
        host.pulse(3);
        rd_chk(uetc_pkg::ADDR_TX_CONTROL, 8'h01, "arm after setup");
        // one byte past the depth, then recover with the clear bit
        for (int i = 0; i <= uetc_pkg::FIFO_DEPTH; i++) begin
            reg_wr(uetc_pkg::ADDR_FIFO_DATA, 8'(i));
        end
        // full and over-run up, empty and under-run down
        rd_chk(uetc_pkg::ADDR_TX_FLAGS, 8'h05, "flags when full");
        check("overrun", 8'h01, {7'h00, v[uetc_pkg::FLG_OVERRUN_POS]});
        reg_wr(uetc_pkg::ADDR_PKT_LENGTH, 8'h08);
        reg_wr(uetc_pkg::ADDR_TX_CONTROL, 8'h83);
        repeat (2) @(posedge ref_clk);
        rd_chk(uetc_pkg::ADDR_TX_CONTROL, 8'h01, "after clear");
        rd_chk(uetc_pkg::ADDR_TX_FLAGS, 8'h08, "flags after clear");
        // function reset keeps the enable but drops stall, arm and length
        reg_wr(uetc_pkg::ADDR_PKT_LENGTH, 8'h02);
        reg_wr(uetc_pkg::ADDR_TX_CONTROL, 8'h0b);
        host.pulse(0);
        rd_chk(uetc_pkg::ADDR_TX_CONTROL, 8'h01, "ctl after freset");
        rd_chk(uetc_pkg::ADDR_PKT_LENGTH, 8'h00, "len after freset");
        reg_wr(uetc_pkg::ADDR_TX_CONTROL, 8'h00);
        @(negedge ref_clk);
        check("disconnect", 8'h01, {7'h00, port_disconnect});
        // with the transmit direction off no answer is offered
        host.in_txn(1'b0);
        check("answer_valid off", 8'h00, {7'h00, host.got_valid});
        wrap_up();
    end
endmodule : usb_ep0_tx_control_tb
